/* File: rtl/rtc_register_map_control.sv */
// serial-bus clock register map, control bits, periodic and alarm outputs
`timescale 1ns/1ps
// Notes on behaviour
// - unused bits ignore writes, read zero
// - power-up flag clears trim and control bits
// - control one layout, default all zeros
// - control two layout, power-up flag defaults one
// - alarm enables gate alarm interrupts
// - hour mode zero 12-hour, one 24-hour
// - 12-hour mode: bit5 is PM, 12 32 21-31
// - clock output stops only with both disables
// - code 000 output high, 001 held low
// - codes 010/011 give 2Hz/1Hz half duty
// - seconds step about 92us after falling edge
// - seconds write resets divider, drives output low
// - level codes: second, minute, hour, month
// - level falling edge at seconds increment
// - trim corrects timing every 20 seconds
// - periodic flag mirrors low output; zero releases level codes
// - alarm flags clear-only; read zero when disabled
// - power-up flag set on supply rise, clear-only
module rtc_register_map_control
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic osc_32k,
   input wire logic supply_rise,
   input wire logic osc_halt,
   input wire logic voltage_low,
   input wire logic weekly_match,
   input wire logic daily_match,
   input wire logic month_last_day,
   output logic irq_a_pin,
   output logic irq_b_pin,
   output logic clkout_pin,
   output logic threshold_select,
   output logic test_mode
);
   import rtc_pkg::*;

   typedef enum {
      st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
      st_wdata, st_wack, st_rdata, st_rack
   } bus_state_t;

   // ==========================================================
   // link side, clocked by the bus clock
   bus_state_t state;
   logic start_tog;
   logic start_seen;
   logic [2:0] bit_cnt;
   logic [6:0] shreg;
   logic [3:0] ptr;
   logic rd_mode;
   logic wr_tog;
   logic rd_tog;
   reg_write_t wr_word;
   logic [7:0] rd_data;
   logic [7:0] in_byte;

   assign in_byte = {shreg, sda_in};

   // start is seen on the data line falling while the clock is high;
   // stop needs no detector since every byte is committed on its own
   always_ff @(negedge sda_in or negedge arst_n)
   begin
      if (!arst_n)
         start_tog <= 1'b0;
      else if (scl)
         start_tog <= ~start_tog;
   end

   always_ff @(posedge scl or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= st_idle;
         start_seen <= 1'b0;
         bit_cnt <= 3'd0;
         shreg <= 7'h00;
         ptr <= 4'h0;
         rd_mode <= 1'b0;
         wr_tog <= 1'b0;
         rd_tog <= 1'b0;
         wr_word <= '0;
      end
      else if (start_tog != start_seen)
      begin
         start_seen <= start_tog;
         shreg <= {6'h00, sda_in};
         bit_cnt <= 3'd1;
         state <= st_addr;
      end
      else
      begin
         unique case (state)
            st_idle: ;
            st_addr, st_ptr, st_wdata:
            begin
               shreg <= in_byte[6:0];
               bit_cnt <= bit_cnt + 3'd1;
               if (bit_cnt == 3'd7)
               begin
                  unique case (state)
                     st_addr:
                     begin
                        rd_mode <= in_byte[0];
                        state <= (in_byte[7:1] == BUS_SLAVE_ADDR) ?
                           st_addr_ack : st_idle;
                     end
                     st_ptr:
                     begin
                        ptr <= in_byte[7:4];
                        rd_tog <= ~rd_tog;
                        state <= st_ptr_ack;
                     end
                     default:
                     begin
                        wr_word <= '{addr: ptr, data: in_byte};
                        wr_tog <= ~wr_tog;
                        ptr <= ptr + 4'h1;
                        rd_tog <= ~rd_tog;
                        state <= st_wack;
                     end
                  endcase
               end
            end
            st_addr_ack:
            begin
               bit_cnt <= 3'd0;
               state <= rd_mode ? st_rdata : st_ptr;
            end
            st_ptr_ack, st_wack:
            begin
               bit_cnt <= 3'd0;
               state <= st_wdata;
            end
            st_rdata:
            begin
               bit_cnt <= bit_cnt + 3'd1;
               if (bit_cnt == 3'd7)
               begin
                  ptr <= ptr + 4'h1;
                  rd_tog <= ~rd_tog;
                  state <= st_rack;
               end
            end
            st_rack:
            begin
               bit_cnt <= 3'd0;
               state <= sda_in ? st_idle : st_rdata;
            end
         endcase
      end
   end

   // data line changes only while the bus clock is low;
   // rd_data was fetched at least one bit time earlier, so it is settled
   always_ff @(negedge scl or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0;
         unique case (state)
            st_addr_ack, st_ptr_ack, st_wack: sda_oe <= 1'b1;
            st_rdata: sda_oe <= ~rd_data[3'd7 - bit_cnt];
            default: sda_oe <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // crossings into the system clock
   logic wr_s1, wr_s2, wr_s3;
   logic rd_s1, rd_s2, rd_s3;
   logic osc_s1, osc_s2, osc_s3;
   logic pwr_s1, pwr_s2, pwr_s3;
   logic halt_s1, halt_s2;
   logic vlow_s1, vlow_s2;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {wr_s1, wr_s2, wr_s3} <= 3'b000;
         {rd_s1, rd_s2, rd_s3} <= 3'b000;
         {osc_s1, osc_s2, osc_s3} <= 3'b000;
         {pwr_s1, pwr_s2, pwr_s3} <= 3'b000;
         {halt_s1, halt_s2} <= 2'b00;
         {vlow_s1, vlow_s2} <= 2'b00;
      end
      else
      begin
         {wr_s1, wr_s2, wr_s3} <= {wr_tog, wr_s1, wr_s2};
         {rd_s1, rd_s2, rd_s3} <= {rd_tog, rd_s1, rd_s2};
         {osc_s1, osc_s2, osc_s3} <= {osc_32k, osc_s1, osc_s2};
         {pwr_s1, pwr_s2, pwr_s3} <= {supply_rise, pwr_s1, pwr_s2};
         {halt_s1, halt_s2} <= {osc_halt, halt_s1};
         {vlow_s1, vlow_s2} <= {voltage_low, vlow_s1};
      end
   end

   logic wr_ev, rd_ev, tick, pwr_ev;
   logic [7:0] wdata;
   assign wr_ev = wr_s2 ^ wr_s3;
   assign rd_ev = rd_s2 ^ rd_s3;
   assign tick = osc_s2 & ~osc_s3;
   assign pwr_ev = pwr_s2 & ~pwr_s3;
   assign wdata = wr_word.data & live_bits(wr_word.addr);

   function automatic logic wr_at(input logic [3:0] a);
      return wr_ev && wr_word.addr == a;
   endfunction

   // ==========================================================
   // registers
   logic [7:0] seconds_count, minutes_count, hours_count;
   logic [7:0] rate_trim;
   logic [7:0] plain_store [0:15];
   control_one_t control_one;
   control_two_t control_two;
   logic [15:0] div_cnt;
   logic [7:0] cur_adj;
   logic [4:0] trim_sec;
   logic periodic_low;

   logic [15:0] adj16, div_end;
   logic wrap, sec_inc, ev_min, ev_hour, ev_day, ev_month;
   logic [5:0] trim_steps;
   logic [7:0] next_adj;
   logic pulse_low;

   assign adj16 = {{8{cur_adj[7]}}, cur_adj};
   assign div_end = DIV_PERIOD - 16'd1 + adj16;
   assign wrap = tick && div_cnt == div_end;
   assign sec_inc = tick && div_cnt == INC_DELAY_TICKS;
   assign ev_min = sec_inc && seconds_count == 8'h59;
   assign ev_hour = ev_min && minutes_count == 8'h59;
   assign ev_day = ev_hour && (control_one.hour_mode_24 ?
      hours_count == 8'h23 : hours_count == 8'h31);
   assign ev_month = ev_day && month_last_day;
   assign trim_steps = (rate_trim[5:0] > 6'd1) ?
      rate_trim[5:0] - 6'd1 : 6'd0;
   // two oscillator ticks per step keep the worst case near 3.8 ms
   assign next_adj = rate_trim[6] ? 8'd0 - {1'b0, trim_steps, 1'b0} :
      {1'b0, trim_steps, 1'b0};

   // sub-second divider; a seconds write restarts it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_cnt <= 16'h0000;
         cur_adj <= 8'h00;
         trim_sec <= 5'd0;
      end
      else if (wr_at(ADDR_SECONDS))
         div_cnt <= 16'h0000;
      else if (wrap)
      begin
         div_cnt <= 16'h0000;
         trim_sec <= (trim_sec == TRIM_WINDOW_SEC - 5'd1) ?
            5'd0 : trim_sec + 5'd1;
         cur_adj <= (trim_sec == TRIM_WINDOW_SEC - 5'd1) ?
            next_adj : 8'h00;
      end
      else if (tick)
         div_cnt <= div_cnt + 16'd1;
   end

   // time counters; other calendar fields are plain storage here
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         seconds_count <= PLAIN_RESET;
         minutes_count <= PLAIN_RESET;
         hours_count <= PLAIN_RESET;
      end
      else
      begin
         if (wr_at(ADDR_SECONDS))
            seconds_count <= wdata;
         else if (sec_inc)
            seconds_count <= ev_min ? 8'h00 : bcd_inc(seconds_count);
         if (wr_at(ADDR_MINUTES))
            minutes_count <= wdata;
         else if (ev_min)
            minutes_count <= ev_hour ? 8'h00 : bcd_inc(minutes_count);
         if (wr_at(ADDR_HOURS))
            hours_count <= wdata;
         else if (ev_hour && control_one.hour_mode_24)
            hours_count <= ev_day ? 8'h00 : bcd_inc(hours_count);
         else if (ev_hour)
         begin
            unique case (hours_count)
               8'h11: hours_count <= HOUR_NOON_PM;
               8'h31: hours_count <= HOUR_MIDNIGHT_AM;
               8'h12: hours_count <= 8'h01;
               8'h32: hours_count <= 8'h21;
               default: hours_count <= bcd_inc(hours_count & 8'h1f) |
                  (hours_count & 8'h20);
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 16; i++)
            plain_store[i] <= PLAIN_RESET;
      end
      else if (wr_ev)
         plain_store[wr_word.addr] <= wdata;
   end

   // trim and control one; held clear while power-up flag is set
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rate_trim <= PLAIN_RESET;
         control_one <= CONTROL_ONE_RESET;
      end
      else if (control_two.power_up_flag)
      begin
         rate_trim <= PLAIN_RESET;
         control_one <= CONTROL_ONE_RESET;
      end
      else
      begin
         if (wr_at(ADDR_RATE_TRIM))
            rate_trim <= wdata;
         if (wr_at(ADDR_CONTROL_ONE))
            control_one <= wdata;
      end
   end

   // ==========================================================
   // periodic output
   always_comb
   begin
      unique case (control_one.periodic_select)
         per_2hz: pulse_low = div_cnt < DIV_QUARTER + adj16 ||
            (div_cnt >= DIV_HALF + adj16 &&
             div_cnt < DIV_3QUARTER + adj16);
         per_1hz: pulse_low = div_cnt < DIV_HALF + adj16;
         default: pulse_low = 1'b0;
      endcase
   end

   logic ctl2_wr, level_ev;
   assign ctl2_wr = wr_at(ADDR_CONTROL_TWO);
   always_comb
   begin
      unique case (control_one.periodic_select)
         per_sec: level_ev = sec_inc;
         per_min: level_ev = ev_min;
         per_hour: level_ev = ev_hour;
         per_month: level_ev = ev_month;
         default: level_ev = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         periodic_low <= 1'b0;
      else
      begin
         unique case (control_one.periodic_select)
            per_off: periodic_low <= 1'b0;
            per_low: periodic_low <= 1'b1;
            per_2hz, per_1hz: periodic_low <= pulse_low;
            default:
               // a new event wins over a release in the same cycle
               if (level_ev)
                  periodic_low <= 1'b1;
               else if (ctl2_wr && !wdata[2])
                  periodic_low <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // control two
   logic wk_set, dy_set;
   assign wk_set = weekly_match && control_one.weekly_alarm_enable;
   assign dy_set = daily_match && control_one.daily_alarm_enable;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         control_two <= CONTROL_TWO_RESET;
      else
      begin
         if (pwr_ev)
            control_two.power_up_flag <= 1'b1;
         else if (ctl2_wr && !wdata[4])
            control_two.power_up_flag <= 1'b0;
         if (halt_s2)
            control_two.osc_halt_monitor <= 1'b0;
         else if (ctl2_wr)
            control_two.osc_halt_monitor <= wdata[5];
         control_two.periodic_flag <= periodic_low;
         if (control_two.power_up_flag)
         begin
            control_two.threshold_select <= 1'b0;
            control_two.voltage_drop_flag <= 1'b0;
            control_two.clkout_disable_one <= 1'b0;
            control_two.weekly_alarm_flag <= 1'b0;
            control_two.daily_alarm_flag <= 1'b0;
         end
         else
         begin
            if (ctl2_wr)
            begin
               control_two.threshold_select <= wdata[7];
               control_two.clkout_disable_one <= wdata[3];
            end
            if (vlow_s2)
               control_two.voltage_drop_flag <= 1'b1;
            else if (ctl2_wr && !wdata[6])
               control_two.voltage_drop_flag <= 1'b0;
            if (!control_one.weekly_alarm_enable)
               control_two.weekly_alarm_flag <= 1'b0;
            else if (wk_set)
               control_two.weekly_alarm_flag <= 1'b1;
            else if (ctl2_wr && !wdata[1])
               control_two.weekly_alarm_flag <= 1'b0;
            if (!control_one.daily_alarm_enable)
               control_two.daily_alarm_flag <= 1'b0;
            else if (dy_set)
               control_two.daily_alarm_flag <= 1'b1;
            else if (ctl2_wr && !wdata[0])
               control_two.daily_alarm_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read-back for the link and output pins
   function automatic logic [7:0] read_reg(input logic [3:0] a);
      logic [7:0] v;
      unique case (a)
         ADDR_SECONDS: v = seconds_count;
         ADDR_MINUTES: v = minutes_count;
         ADDR_HOURS: v = hours_count;
         ADDR_RATE_TRIM: v = rate_trim;
         ADDR_CONTROL_ONE: v = control_one;
         ADDR_CONTROL_TWO: v = control_two;
         default: v = plain_store[a];
      endcase
      return v & live_bits(a);
   endfunction

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_data <= 8'h00;
         irq_a_pin <= 1'b1;
         irq_b_pin <= 1'b1;
         clkout_pin <= 1'b0;
         threshold_select <= 1'b0;
         test_mode <= 1'b0;
      end
      else
      begin
         if (rd_ev)
            rd_data <= read_reg(ptr);
         irq_a_pin <= ~(control_two.daily_alarm_flag | periodic_low);
         irq_b_pin <= ~control_two.weekly_alarm_flag;
         clkout_pin <= osc_s2 & ~(control_two.clkout_disable_one &
            control_one.clkout_disable_two);
         threshold_select <= control_two.threshold_select;
         test_mode <= control_one.test_mode;
      end
   end

endmodule

/* File: rtl/rtc_pkg.sv */
// shared constants, field layouts and carriers for the clock register block
package rtc_pkg;

   // ==========================================================
   // register locations
   localparam logic [3:0] ADDR_SECONDS = 4'h0;
   localparam logic [3:0] ADDR_MINUTES = 4'h1;
   localparam logic [3:0] ADDR_HOURS = 4'h2;
   localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
   localparam logic [3:0] ADDR_MONTHDAY = 4'h4;
   localparam logic [3:0] ADDR_MONTH = 4'h5;
   localparam logic [3:0] ADDR_YEAR = 4'h6;
   localparam logic [3:0] ADDR_RATE_TRIM = 4'h7;
   localparam logic [3:0] ADDR_W_MINUTE = 4'h8;
   localparam logic [3:0] ADDR_W_HOUR = 4'h9;
   localparam logic [3:0] ADDR_W_DAYS = 4'ha;
   localparam logic [3:0] ADDR_D_MINUTE = 4'hb;
   localparam logic [3:0] ADDR_D_HOUR = 4'hc;
   localparam logic [3:0] ADDR_UNUSED = 4'hd;
   localparam logic [3:0] ADDR_CONTROL_ONE = 4'he;
   localparam logic [3:0] ADDR_CONTROL_TWO = 4'hf;

   // ==========================================================
   // values after reset and at 12-hour rollover
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_TWO_RESET = 8'h10;
   localparam logic [7:0] PLAIN_RESET = 8'h00;
   localparam logic [7:0] HOUR_NOON_PM = 8'h32;
   localparam logic [7:0] HOUR_MIDNIGHT_AM = 8'h12;

   // serial bus slave address; value is arbitrary
   localparam logic [6:0] BUS_SLAVE_ADDR = 7'h32;

   // ==========================================================
   // timing
   localparam int OSC_HZ = 32768;
   localparam int INC_DELAY_US = 92;
   localparam logic [15:0] INC_DELAY_TICKS =
      16'((INC_DELAY_US * OSC_HZ) / 1000000);
   localparam logic [15:0] DIV_PERIOD = 16'(OSC_HZ);
   localparam logic [15:0] DIV_QUARTER = 16'(OSC_HZ / 4);
   localparam logic [15:0] DIV_HALF = 16'(OSC_HZ / 2);
   localparam logic [15:0] DIV_3QUARTER = 16'((OSC_HZ * 3) / 4);
   localparam logic [4:0] TRIM_WINDOW_SEC = 5'd20;

   // ==========================================================
   // field layouts
   typedef enum logic [2:0] {
      per_off, per_low, per_2hz, per_1hz,
      per_sec, per_min, per_hour, per_month
   } periodic_sel_t;

   typedef struct packed {
      logic weekly_alarm_enable;
      logic daily_alarm_enable;
      logic hour_mode_24;
      logic clkout_disable_two;
      logic test_mode;
      periodic_sel_t periodic_select;
   } control_one_t;

   typedef struct packed {
      logic threshold_select;
      logic voltage_drop_flag;
      logic osc_halt_monitor;
      logic power_up_flag;
      logic clkout_disable_one;
      logic periodic_flag;
      logic weekly_alarm_flag;
      logic daily_alarm_flag;
   } control_two_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } reg_write_t;

   // bits that exist in each location; the rest read zero
   function automatic logic [7:0] live_bits(input logic [3:0] a);
      logic [7:0] m;
      m = 8'h00;
      unique case (a)
         4'h0, 4'h1, 4'h7, 4'h8, 4'ha, 4'hb: m = 8'h7f;
         4'h2, 4'h4, 4'h9, 4'hc: m = 8'h3f;
         4'h3: m = 8'h07;
         4'h5: m = 8'h9f;
         4'h6, 4'he, 4'hf: m = 8'hff;
         4'hd: m = 8'h00;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
      return r;
   endfunction

endpackage

/* File: sim/rtc_map_sva.sv */
// port assertions for the clock register block
`timescale 1ns/1ps
module rtc_map_sva
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic osc_32k,
   input wire logic supply_rise,
   input wire logic weekly_match,
   input wire logic irq_b_pin,
   input wire logic clkout_pin,
   input wire logic threshold_select
);
   // ==========================================
   // cycles since bus or supply activity
   logic scl_q;
   logic [3:0] quiet;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         scl_q <= 1'b1;
      else
         scl_q <= scl;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         quiet <= 4'h0;
      else if (scl != scl_q || supply_rise)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ==========================================
   // assertions
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   ack_when_low_a: assert property ($rose(sda_oe) |-> !scl)
      else $error("data pulled while bus clock high");
   drop_when_low_a: assert property ($fell(sda_oe) |-> !scl)
      else $error("data released while bus clock high");
   clk_idle_a: assert property ((!osc_32k) [*4] |=> !clkout_pin)
      else $error("clock output high with source low");
   clk_source_a: assert property ($rose(clkout_pin) |->
      $past(osc_32k, 2) || $past(osc_32k, 3) || $past(osc_32k, 4))
      else $error("clock output rose without source");
   weekly_set_a: assert property ($fell(irq_b_pin) |->
      $past(weekly_match) || $past(weekly_match, 2)
      || $past(weekly_match, 3))
      else $error("weekly pin fell without match");
   weekly_clear_a: assert property ($rose(irq_b_pin) |-> quiet < 4'd8)
      else $error("weekly pin released without host write");
   thresh_write_a: assert property ($changed(threshold_select) |->
      quiet < 4'd8)
      else $error("threshold changed without host write");
endmodule
bind rtc_register_map_control rtc_map_sva chk (.clk(clk), .arst_n(arst_n),
   .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .osc_32k(osc_32k), .supply_rise(supply_rise),
   .weekly_match(weekly_match), .irq_b_pin(irq_b_pin),
   .clkout_pin(clkout_pin), .threshold_select(threshold_select));

/* File: sim/rtc_host_model.sv */
// host bus master model, 160 ns per bit, bus clock idles high
`timescale 1ns/1ps
module rtc_host_model
   import rtc_pkg::*;
(
   output logic scl,
   output logic sda_h,
   input wire logic sda_w
);
   // ==========================================
   // bit and frame timing
   logic nak;
   initial
   begin
      scl = 1'b1;
      sda_h = 1'b1;
      nak = 1'b0;
   end
   task automatic bit_io(input logic b, output logic r);
      sda_h = b;
      #40 scl = 1'b1;
      #40 r = sda_w;
      #40 scl = 1'b0;
      #40;
   endtask
   // doubles as repeated start: data rises first while clock is low
   task automatic frame_start();
      sda_h = 1'b1;
      #40 scl = 1'b1;
      #40 sda_h = 1'b0;
      #40 scl = 1'b0;
   endtask
   task automatic frame_stop();
      sda_h = 1'b0;
      #40 scl = 1'b1;
      #40 sda_h = 1'b1;
      #40;
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
      output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(1'b1, k);
   endtask
   // ==========================================
   // register accesses
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic k1, k2, k3;
      frame_start();
      byte_io({BUS_SLAVE_ADDR, 1'b0}, q, k1);
      byte_io({a, 4'h0}, q, k2);
      byte_io(d, q, k3);
      frame_stop();
      nak = nak | k1 | k2 | k3;
   endtask
   // a read ends with a nack so the device lets go of the line
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      logic [7:0] q;
      logic k1, k2, k3, k4;
      frame_start();
      byte_io({BUS_SLAVE_ADDR, 1'b0}, q, k1);
      byte_io({a, 4'h0}, q, k2);
      frame_start();
      byte_io({BUS_SLAVE_ADDR, 1'b1}, q, k3);
      byte_io(8'hff, d, k4);
      frame_stop();
      nak = nak | k1 | k2 | k3;
   endtask
endmodule

/* File: sim/rtc_register_map_control_tb.sv */
// self-checking bench for the clock register block
`timescale 1ns/1ps
module rtc_register_map_control_tb;
   import rtc_pkg::*;
   logic clk, arst_n, scl, sda_h, sda_w, sda_oe, osc_32k, seen;
   logic supply_rise, weekly_match, daily_match, irq_a_pin, irq_b_pin;
   logic clkout_pin, threshold_select, test_mode;
   int failures, cmp_count;
   logic [7:0] mask [14] = '{8'h59, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h9f,
      8'hff, 8'h7f, 8'h7f, 8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'h00};
   // pull-up on the data line; either party may pull it low
   assign sda_w = sda_h & ~sda_oe;
   rtc_register_map_control DUT (.clk(clk), .arst_n(arst_n), .scl(scl),
      .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .osc_32k(osc_32k),
      .supply_rise(supply_rise), .osc_halt(1'b0), .voltage_low(1'b0),
      .weekly_match(weekly_match), .daily_match(daily_match),
      .month_last_day(1'b0), .irq_a_pin(irq_a_pin),
      .irq_b_pin(irq_b_pin), .clkout_pin(clkout_pin),
      .threshold_select(threshold_select), .test_mode(test_mode));
   rtc_host_model host (.scl(scl), .sda_h(sda_h), .sda_w(sda_w));
   always #12.5 clk = ~clk;
   // sped-up oscillator; a second still lasts far beyond this run
   always
   begin
      repeat (4) @(negedge clk);
      osc_32k = ~osc_32k;
   end
   // ==========================================
   // checking and reporting
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(input logic w);
      @(negedge clk);
      weekly_match = w;
      daily_match = ~w;
      @(negedge clk);
      weekly_match = 1'b0;
      daily_match = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic watch(output logic hi);
      hi = 1'b0;
      repeat (40) @(negedge clk)
         hi = hi | clkout_pin;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #1000000;
      failures++;
      report_and_stop();
   end
   // ==========================================
   // tests
   initial
   begin
      clk = 1'b0;
      arst_n = 1'b0;
      osc_32k = 1'b0;
      supply_rise = 1'b0;
      weekly_match = 1'b0;
      daily_match = 1'b0;
      failures = 0;
      cmp_count = 0;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      rchk(ADDR_CONTROL_ONE, CONTROL_ONE_RESET);
      rchk(ADDR_CONTROL_TWO, CONTROL_TWO_RESET);
      host.wr(ADDR_CONTROL_ONE, 8'h40);
      rchk(ADDR_CONTROL_ONE, 8'h00);
      host.wr(ADDR_CONTROL_TWO, 8'h00);
      rchk(ADDR_CONTROL_TWO, 8'h00);
      $display("test defaults done");
      host.wr(ADDR_CONTROL_ONE, 8'h20);
      rchk(ADDR_CONTROL_ONE, 8'h20);
      for (int a = 0; a < 14; a++)
      begin
         host.wr(4'(a), (a == 7) ? 8'h7f : (a == 0) ? 8'hd8 : 8'hff);
         rchk(4'(a), mask[a]);
      end
      host.wr(ADDR_CONTROL_ONE, 8'h00);
      host.wr(ADDR_HOURS, 8'h31);
      rchk(ADDR_HOURS, 8'h31);
      $display("test layout done");
      host.wr(ADDR_CONTROL_ONE, 8'h10);
      watch(seen);
      chk({7'h00, seen}, 8'h01);
      host.wr(ADDR_CONTROL_TWO, 8'h08);
      watch(seen);
      chk({7'h00, seen}, 8'h00);
      host.wr(ADDR_CONTROL_ONE, 8'h00);
      watch(seen);
      chk({7'h00, seen}, 8'h01);
      $display("test clock output done");
      chk({7'h00, irq_a_pin}, 8'h01);
      host.wr(ADDR_CONTROL_ONE, 8'h01);
      chk({7'h00, irq_a_pin}, 8'h00);
      rchk(ADDR_CONTROL_TWO, 8'h0c);
      host.wr(ADDR_CONTROL_ONE, 8'h00);
      chk({7'h00, irq_a_pin}, 8'h01);
      host.wr(ADDR_CONTROL_ONE, 8'h04);
      host.wr(ADDR_SECONDS, 8'h00);
      repeat (40) @(negedge clk);
      chk({7'h00, irq_a_pin}, 8'h00);
      host.wr(ADDR_CONTROL_TWO, 8'h08);
      chk({7'h00, irq_a_pin}, 8'h01);
      $display("test periodic done");
      pulse(1'b1);
      chk({7'h00, irq_b_pin}, 8'h01);
      host.wr(ADDR_CONTROL_ONE, 8'hc0);
      pulse(1'b1);
      chk({7'h00, irq_b_pin}, 8'h00);
      pulse(1'b0);
      chk({7'h00, irq_a_pin}, 8'h00);
      host.wr(ADDR_CONTROL_TWO, 8'h0b);
      rchk(ADDR_CONTROL_TWO, 8'h0b);
      host.wr(ADDR_CONTROL_TWO, 8'h01);
      chk({7'h00, irq_b_pin}, 8'h01);
      rchk(ADDR_CONTROL_TWO, 8'h01);
      host.wr(ADDR_CONTROL_ONE, 8'h80);
      rchk(ADDR_CONTROL_TWO, 8'h00);
      chk({7'h00, irq_a_pin}, 8'h01);
      $display("test alarms done");
      host.wr(ADDR_CONTROL_TWO, 8'h80);
      chk({7'h00, threshold_select}, 8'h01);
      host.wr(ADDR_RATE_TRIM, 8'h15);
      @(negedge clk);
      supply_rise = 1'b1;
      repeat (8) @(negedge clk);
      supply_rise = 1'b0;
      chk({7'h00, threshold_select}, 8'h00);
      rchk(ADDR_CONTROL_TWO, CONTROL_TWO_RESET);
      rchk(ADDR_RATE_TRIM, 8'h00);
      rchk(ADDR_CONTROL_ONE, 8'h00);
      chk({7'h00, test_mode}, 8'h00);
      chk({7'h00, host.nak}, 8'h00);
      $display("test power up done");
      report_and_stop();
   end
endmodule
